// ===== design/sbhm_ctrl.sv
// standby halt mode controller with its axi4-lite register slave
// Contract
// R1: in light sleep only oscillator and watchdog run, system clock stops and the clock output is held at one.
// R2: in light sleep the wake request is seen without the system clock, but execution resumes in step with it.
// R3: in light sleep every interrupt but the non-maskable one is ignored; only it or reset ends the halt.
// R4: peripheral sleep leaves halt with run-mode timing and clocks only the timers and the serial interface.
// R5: in peripheral sleep the two external interrupt pins do not end the halt; timer, serial, nmi and reset do.
// R6: stop mode stops every circuit including the oscillator and floats the pins unless pin hold is on.
// R7: stop mode rejects all interrupts so only reset ends it, and programmable pull-ups stay on.
// R8: the outside holds the nmi pin at one for the whole stop halt.
// R9: with the pin hold bit (bit 0, reset zero) set, outputs keep their pre-halt state in stop mode.
// R10: in stop mode without pin hold, inputs are not used and outputs float.
// R11: the outside holds reset low long enough for the oscillator to settle when leaving stop.
// R12: the outside holds the level-mode first external interrupt high through the second response bus cycle.
// R13: the halt mode is bits 3:2 of standby_control, reset to run: 00 run, 01 stop, 10 light, 11 peripheral.
// R14: in run halt the system clock keeps running, the core does dummy cycles and requests are sampled on aclk.
// R15: a halt instruction enters the selected mode, and reset ends the halt in every mode.
`timescale 1ns/1ps
module sbhm_ctrl (
   input  wire logic                   aclk,
   input  wire logic                   aresetn,
   input  wire logic [17:0]            s_axi_awaddr,
   input  wire logic                   s_axi_awvalid,
   output logic                        s_axi_awready,
   input  wire logic [31:0]            s_axi_wdata,
   input  wire logic [3:0]             s_axi_wstrb,
   input  wire logic                   s_axi_wvalid,
   output logic                        s_axi_wready,
   output logic [1:0]                  s_axi_bresp,
   output logic                        s_axi_bvalid,
   input  wire logic                   s_axi_bready,
   input  wire logic [17:0]            s_axi_araddr,
   input  wire logic                   s_axi_arvalid,
   output logic                        s_axi_arready,
   output logic [31:0]                 s_axi_rdata,
   output logic [1:0]                  s_axi_rresp,
   output logic                        s_axi_rvalid,
   input  wire logic                   s_axi_rready,
   input  wire logic                   halt_exec,
   input  wire logic                   exx_exec,
   input  wire logic                   nmi_n,
   input  wire logic                   first_external_irq,
   input  wire logic                   second_external_irq,
   input  wire sbhm_pkg::sbhm_int_irq_t int_irq,
   output logic                        halted,
   output logic                        halt_release,
   output sbhm_pkg::sbhm_clk_t         clk_ctl,
   output sbhm_pkg::sbhm_pin_t         pin_ctl
);
   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   logic [2:0] pins_s;
   logic       nmi_prev;
   logic       nmi_edge;
   logic       ext_req;
   logic       int_req;

   sbhm_sync3 #(.W(3), .INI(3'h1)) u_sync (
      .aclk    (aclk),
      .aresetn (aresetn),
      .pin     ({second_external_irq, first_external_irq, nmi_n}),
      .level   (pins_s)
   );

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         nmi_prev <= 1'b1;
      else
         nmi_prev <= pins_s[0];
   end

   // the pin is sampled on the oscillator clock, so no system clock is needed to see it [R2] [R14]
   assign nmi_edge = nmi_prev & ~pins_s[0];
   assign ext_req  = pins_s[1] | pins_s[2];
   assign int_req  = |int_irq;

   // ----------------------------------------
   // registers
   // ----------------------------------------
   sbhm_pkg::sbhm_mode_t  mode_sel;
   logic                  pin_hold;
   logic                  exch;
   logic [17:0]           aw_addr;
   logic                  aw_have;
   logic [31:0]           w_data;
   logic [3:0]            w_strb;
   logic                  w_have;
   logic                  wr_go;
   logic                  wr_ctrl;
   sbhm_pkg::sbhm_state_t st;
   sbhm_pkg::sbhm_state_t next_st;
   sbhm_pkg::sbhm_mode_t  halt_mode;
   logic                  release_ok;

   assign s_axi_awready = ~aw_have & ~s_axi_bvalid;
   assign s_axi_wready  = ~w_have & ~s_axi_bvalid;
   assign wr_go         = aw_have & w_have & ~s_axi_bvalid;
   assign wr_ctrl       = wr_go && aw_addr == sbhm_pkg::SBHM_ADDR_STANDBY_CONTROL && w_strb[0];

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_have      <= 1'b0;
         w_have       <= 1'b0;
         aw_addr      <= 18'h00000;
         w_data       <= 32'h00000000;
         w_strb       <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= sbhm_pkg::SBHM_RESP_OKAY;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_have <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_have <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (wr_go)
         begin
            aw_have      <= 1'b0;
            w_have       <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (aw_addr == sbhm_pkg::SBHM_ADDR_STANDBY_CONTROL) ?
                            sbhm_pkg::SBHM_RESP_OKAY : sbhm_pkg::SBHM_RESP_SLVERR;
         end
         else if (s_axi_bvalid && s_axi_bready)
         begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         mode_sel <= sbhm_sync_mode(sbhm_pkg::SBHM_CTRL_RESET);                      // [R13]
         pin_hold <= sbhm_pkg::SBHM_CTRL_RESET[sbhm_pkg::SBHM_BIT_PIN_HOLD];         // [R9]
         exch     <= sbhm_pkg::SBHM_CTRL_RESET[sbhm_pkg::SBHM_BIT_EXCHANGE];
      end
      else
      begin
         if (wr_ctrl)
         begin
            mode_sel <= sbhm_sync_mode(w_data[7:0]);                                 // [R13]
            pin_hold <= w_data[sbhm_pkg::SBHM_BIT_PIN_HOLD];                         // [R9]
         end
         // the exchange flag is read only; software writes leave it alone
         if (exx_exec)
            exch <= ~exch;
      end
   end

   function automatic sbhm_pkg::sbhm_mode_t sbhm_sync_mode(input logic [7:0] v);
      sbhm_sync_mode = sbhm_pkg::sbhm_mode_t'(v[sbhm_pkg::SBHM_BIT_MODE_HI:sbhm_pkg::SBHM_BIT_MODE_LO]);
   endfunction

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h00000000;
         s_axi_rresp  <= sbhm_pkg::SBHM_RESP_OKAY;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= sbhm_pkg::SBHM_RESP_OKAY;
         if (s_axi_araddr == sbhm_pkg::SBHM_ADDR_STANDBY_CONTROL)
            s_axi_rdata <= {28'h0000000, mode_sel, exch, pin_hold};
         else if (s_axi_araddr == sbhm_pkg::SBHM_ADDR_STATUS)
            s_axi_rdata <= {27'h0000000, clk_ctl.sys_clk_en, clk_ctl.osc_en, halt_mode, halted};
         else
         begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= sbhm_pkg::SBHM_RESP_SLVERR;
         end
      end
      else if (s_axi_rready)
      begin
         s_axi_rvalid <= 1'b0;
      end
   end

   assign s_axi_arready = ~s_axi_rvalid;

   // ----------------------------------------
   // halt state machine
   // ----------------------------------------
   always_comb
   begin
      case (halt_mode)
         sbhm_pkg::SBHM_MODE_RUN:   release_ok = nmi_edge | ext_req | int_req;       // [R14]
         sbhm_pkg::SBHM_MODE_PERI:  release_ok = nmi_edge | int_req;                 // [R5]
         sbhm_pkg::SBHM_MODE_LIGHT: release_ok = nmi_edge;                           // [R3]
         sbhm_pkg::SBHM_MODE_STOP:  release_ok = 1'b0;                               // [R7]
         default:                   release_ok = 1'b0;
      endcase
   end

   always_comb
   begin
      case (st)
         sbhm_pkg::SBHM_S_ACTIVE: next_st = halt_exec ? sbhm_pkg::SBHM_S_HALT : sbhm_pkg::SBHM_S_ACTIVE; // [R15]
         sbhm_pkg::SBHM_S_HALT:   next_st = release_ok ? sbhm_pkg::SBHM_S_WAKE : sbhm_pkg::SBHM_S_HALT;
         // one resume cycle in every mode a request can end (not stop), so the restart lands on a system clock edge [R2] [R4]
         sbhm_pkg::SBHM_S_WAKE:   next_st = sbhm_pkg::SBHM_S_ACTIVE;
         default:                 next_st = sbhm_pkg::SBHM_S_ACTIVE;
      endcase
   end

   // reset is the release that every mode honours, stop included [R15]
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         st        <= sbhm_pkg::SBHM_S_ACTIVE;
         halt_mode <= sbhm_pkg::SBHM_MODE_RUN;
      end
      else
      begin
         st <= next_st;
         if (st == sbhm_pkg::SBHM_S_ACTIVE && halt_exec)
            halt_mode <= mode_sel;                                                   // [R15]
      end
   end

   // ----------------------------------------
   // clock and pin control
   // ----------------------------------------
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         halted       <= 1'b0;
         halt_release <= 1'b0;
         clk_ctl      <= '{osc_en: 1'b1, wdt_clk_en: 1'b1, sys_clk_en: 1'b1,
                           timer_clk_en: 1'b1, serial_clk_en: 1'b1, clk_out_high: 1'b0};
         pin_ctl      <= '0;
      end
      else
      begin
         halted       <= next_st == sbhm_pkg::SBHM_S_HALT;
         // the pulse marks the first active cycle, one resume cycle after the wake [R2]
         halt_release <= st == sbhm_pkg::SBHM_S_WAKE;
         clk_ctl      <= '{osc_en: 1'b1, wdt_clk_en: 1'b1, sys_clk_en: 1'b1,
                           timer_clk_en: 1'b1, serial_clk_en: 1'b1, clk_out_high: 1'b0};
         pin_ctl      <= '0;
         if (next_st == sbhm_pkg::SBHM_S_HALT)
         begin
            case (next_st == st ? halt_mode : mode_sel)
               sbhm_pkg::SBHM_MODE_LIGHT:
               begin
                  clk_ctl.sys_clk_en    <= 1'b0;                                     // [R1]
                  clk_ctl.timer_clk_en  <= 1'b0;
                  clk_ctl.serial_clk_en <= 1'b0;
                  clk_ctl.clk_out_high  <= 1'b1;                                     // [R1]
               end
               sbhm_pkg::SBHM_MODE_PERI:
               begin
                  clk_ctl.sys_clk_en    <= 1'b0;                                     // [R4]
                  clk_ctl.wdt_clk_en    <= 1'b0;
               end
               sbhm_pkg::SBHM_MODE_STOP:
               begin
                  // nothing is left running, so only reset can bring the part back
                  clk_ctl               <= '0;                                       // [R6]
                  clk_ctl.clk_out_high  <= pin_hold;                                 // [R9]
                  pin_ctl.hold_outputs  <= pin_hold;                                 // [R9]
                  pin_ctl.float_outputs <= ~pin_hold;                                // [R6] [R10]
                  pin_ctl.block_inputs  <= ~pin_hold;                                // [R10]
                  pin_ctl.keep_pullups  <= 1'b1;                                     // [R7]
               end
               default:
               begin
                  pin_ctl.hold_outputs  <= 1'b0;
               end
            endcase
         end
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   sequence seq_light_halt;
      st == sbhm_pkg::SBHM_S_HALT && halt_mode == sbhm_pkg::SBHM_MODE_LIGHT;
   endsequence
   sequence seq_resume;
      st == sbhm_pkg::SBHM_S_WAKE ##1 st == sbhm_pkg::SBHM_S_ACTIVE && halt_release;
   endsequence

   AST_LIGHT_CLOCKS: assert property (@(posedge aclk) disable iff (!aresetn)   // [R1]
      seq_light_halt ##1 st == sbhm_pkg::SBHM_S_HALT |->
      !clk_ctl.sys_clk_en && clk_ctl.clk_out_high && clk_ctl.osc_en && clk_ctl.wdt_clk_en)
      else $error("light sleep clocks wrong");
   AST_LIGHT_WAKE: assert property (@(posedge aclk) disable iff (!aresetn)     // [R2]
      seq_light_halt and nmi_edge |=> seq_resume)
      else $error("light sleep did not resume on nmi");
   AST_LIGHT_IGNORE: assert property (@(posedge aclk) disable iff (!aresetn)   // [R3]
      seq_light_halt and !nmi_edge |=> st == sbhm_pkg::SBHM_S_HALT)
      else $error("light sleep left halt without nmi");
   AST_PERI_CLOCKS: assert property (@(posedge aclk) disable iff (!aresetn)    // [R4]
      st == sbhm_pkg::SBHM_S_HALT && halt_mode == sbhm_pkg::SBHM_MODE_PERI && $stable(st) |->
      clk_ctl.timer_clk_en && clk_ctl.serial_clk_en && !clk_ctl.sys_clk_en)
      else $error("peripheral sleep clocks wrong");
   AST_PERI_NO_EXT: assert property (@(posedge aclk) disable iff (!aresetn)    // [R5]
      st == sbhm_pkg::SBHM_S_HALT && halt_mode == sbhm_pkg::SBHM_MODE_PERI && !nmi_edge && !int_req
      |=> st == sbhm_pkg::SBHM_S_HALT)
      else $error("peripheral sleep released by external pin");
   AST_STOP_FLOAT: assert property (@(posedge aclk) disable iff (!aresetn)     // [R6]
      st == sbhm_pkg::SBHM_S_HALT && halt_mode == sbhm_pkg::SBHM_MODE_STOP && $stable(st) && !pin_hold |->
      !clk_ctl.osc_en && pin_ctl.float_outputs && pin_ctl.block_inputs && pin_ctl.keep_pullups)
      else $error("stop mode pins or oscillator wrong");
   AST_STOP_STAYS: assert property (@(posedge aclk) disable iff (!aresetn)     // [R7]
      st == sbhm_pkg::SBHM_S_HALT && halt_mode == sbhm_pkg::SBHM_MODE_STOP |=> halted [*2])
      else $error("stop mode left without reset");
   AST_STOP_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)      // [R9]
      st == sbhm_pkg::SBHM_S_HALT && halt_mode == sbhm_pkg::SBHM_MODE_STOP && $stable(st) && pin_hold |->
      pin_ctl.hold_outputs && !pin_ctl.float_outputs)
      else $error("stop mode pin hold ignored");
   AST_ENTER: assert property (@(posedge aclk) disable iff (!aresetn)          // [R15]
      st == sbhm_pkg::SBHM_S_ACTIVE && halt_exec |=> halted && halt_mode == $past(mode_sel))
      else $error("halt entry wrong");
   AST_RUN_CLOCK: assert property (@(posedge aclk) disable iff (!aresetn)      // [R14]
      st == sbhm_pkg::SBHM_S_HALT && halt_mode == sbhm_pkg::SBHM_MODE_RUN |-> clk_ctl.sys_clk_en)
      else $error("run mode halt stopped the system clock");
   AST_RUN_TIMING: assert property (@(posedge aclk) disable iff (!aresetn)     // [R14]
      st == sbhm_pkg::SBHM_S_HALT && halt_mode == sbhm_pkg::SBHM_MODE_RUN && int_req |=> seq_resume)
      else $error("run mode halt wrong");
endmodule

// ===== design/sbhm_pkg.sv
// package: constants, states and carrier types of the standby halt controller
package sbhm_pkg;
   // ----------------------------------------
   // register map
   // ----------------------------------------
   localparam logic [17:0] SBHM_IDX_STANDBY_CONTROL = 18'h0FF8F;
   localparam logic [17:0] SBHM_IDX_STATUS          = 18'h0FF90;
   localparam logic [17:0] SBHM_ADDR_STANDBY_CONTROL = 18'(SBHM_IDX_STANDBY_CONTROL * 4);
   localparam logic [17:0] SBHM_ADDR_STATUS          = 18'(SBHM_IDX_STATUS * 4);
   localparam int          SBHM_ADDR_W              = 18;
   // ----------------------------------------
   // standby_control fields
   // ----------------------------------------
   localparam int          SBHM_BIT_PIN_HOLD  = 0;
   localparam int          SBHM_BIT_EXCHANGE  = 1;
   localparam int          SBHM_BIT_MODE_LO   = 2;
   localparam int          SBHM_BIT_MODE_HI   = 3;
   localparam logic [7:0]  SBHM_CTRL_RESET    = 8'h00;
   // ----------------------------------------
   // status fields
   // ----------------------------------------
   localparam int          SBHM_ST_HALTED     = 0;
   localparam int          SBHM_ST_MODE_LO    = 1;
   localparam int          SBHM_ST_MODE_HI    = 2;
   localparam int          SBHM_ST_OSC        = 3;
   localparam int          SBHM_ST_SYSCLK     = 4;
   // ----------------------------------------
   // bus answers
   // ----------------------------------------
   localparam logic [1:0]  SBHM_RESP_OKAY     = 2'h0;
   localparam logic [1:0]  SBHM_RESP_SLVERR   = 2'h2;
   // ----------------------------------------
   // types
   // ----------------------------------------
   typedef enum logic [1:0] {
      SBHM_MODE_RUN   = 2'h0,
      SBHM_MODE_STOP  = 2'h1,
      SBHM_MODE_LIGHT = 2'h2,
      SBHM_MODE_PERI  = 2'h3
   } sbhm_mode_t;

   typedef enum logic [1:0] {
      SBHM_S_ACTIVE = 2'h0,
      SBHM_S_HALT   = 2'h1,
      SBHM_S_WAKE   = 2'h3
   } sbhm_state_t;

   typedef struct packed {
      logic osc_en;
      logic wdt_clk_en;
      logic sys_clk_en;
      logic timer_clk_en;
      logic serial_clk_en;
      logic clk_out_high;
   } sbhm_clk_t;

   typedef struct packed {
      logic hold_outputs;
      logic float_outputs;
      logic block_inputs;
      logic keep_pullups;
   } sbhm_pin_t;

   typedef struct packed {
      logic timer_zero_irq;
      logic timer_one_irq;
      logic timer_two_irq;
      logic timer_three_irq;
      logic serial_receive_irq;
      logic serial_transmit_irq;
   } sbhm_int_irq_t;
endpackage

// ===== design/sbhm_sync3.sv
// three-stage pin synchroniser whose output moves once stages two and three agree
`timescale 1ns/1ps
module sbhm_sync3 #(
   parameter int          W   = 1,
   parameter logic [W-1:0] INI = '0
)(
   input  wire logic         aclk,
   input  wire logic         aresetn,
   input  wire logic [W-1:0] pin,
   output logic      [W-1:0] level
);
   logic [W-1:0] s1;
   logic [W-1:0] s2;
   logic [W-1:0] s3;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s1    <= INI;
         s2    <= INI;
         s3    <= INI;
         level <= INI;
      end
      else
      begin
         s1 <= pin;
         s2 <= s1;
         s3 <= s2;
         // a lone glitch that only reaches stage two is not taken
         for (int i = 0; i < W; i++)
         begin
            if (s2[i] == s3[i])
            begin
               level[i] <= s3[i];
            end
         end
      end
   end
endmodule

// ===== testbench/sbhm_partner.sv
// model of the outside: reset pin, nmi pin and the two external interrupt pins
`timescale 1ns/1ps
module sbhm_partner (
   input  wire logic       aclk,
   input  wire logic       halted,
   input  wire logic       go,
   input  wire logic [1:0] fire,
   input  wire logic       rst_req,
   output logic            aresetn,
   output logic            nmi_n,
   output logic            first_external_irq,
   output logic            second_external_irq
);
   logic [3:0] rst_cnt = 4'h3;
   logic [2:0] nmi_cnt = 3'h0;
   logic [1:0] post    = 2'h0;
   // ----------------------------------------
   // reset pin
   // ----------------------------------------
   // a reset that ends stop is held long, so the restarted oscillator settles
   always_ff @(posedge aclk)
   begin
      if (rst_req)
         rst_cnt <= 4'h6;
      else if (rst_cnt != 4'h0)
         rst_cnt <= rst_cnt - 4'h1;
   end
   assign aresetn = (rst_cnt == 4'h0);
   // ----------------------------------------
   // pins
   // ----------------------------------------
   // nmi rests at one, stop halts included; only a commanded pulse lowers it
   always_ff @(posedge aclk)
   begin
      if (go && fire == 2'h0)
         nmi_cnt <= 3'h4;
      else if (nmi_cnt != 3'h0)
         nmi_cnt <= nmi_cnt - 3'h1;
   end
   assign nmi_n = (nmi_cnt == 3'h0);
   // level requests stay up through the response, two cycles past the wake
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         first_external_irq  <= 1'b0;
         second_external_irq <= 1'b0;
         post                <= 2'h0;
      end
      else
      begin
         if (go && fire == 2'h1)
            first_external_irq <= 1'b1;
         if (go && fire == 2'h2)
            second_external_irq <= 1'b1;
         if (halted)
            post <= 2'h2;
         else if (post != 2'h0)
            post <= post - 2'h1;
         if (!halted && post == 2'h1)
         begin
            first_external_irq  <= 1'b0;
            second_external_irq <= 1'b0;
         end
      end
   end
endmodule

// ===== testbench/standby_halt_mode_control_bench.sv
// self-checking bench of the standby halt controller
`timescale 1ns/1ps
module standby_halt_mode_control_bench;
   typedef struct packed {
      logic [1:0] mode;
      logic       hold;
      logic [1:0] src;
      logic       rel;
      logic [5:0] clk;
      logic [3:0] pin;
   } sbhm_row_t;
   // ----------------------------------------
   // signals
   // ----------------------------------------
   logic                    aclk = 1'b0;
   logic                    aresetn;
   logic [17:0]             awaddr = '0, araddr = '0;
   logic                    awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [31:0]             wdata = '0;
   logic                    awready, wready, bvalid, arready, rvalid;
   logic [1:0]              bresp, rresp;
   logic [31:0]             rdata;
   logic                    halt_exec = 1'b0, exx_exec = 1'b0, go = 1'b0, rst_req = 1'b0;
   logic [1:0]              fire = 2'h0;
   logic                    nmi_n, first_external_irq, second_external_irq, halted, halt_release;
   sbhm_pkg::sbhm_int_irq_t int_irq = '0;
   sbhm_pkg::sbhm_clk_t     clk_ctl;
   sbhm_pkg::sbhm_pin_t     pin_ctl;
   int                      errors = 0, total_checks = 0, cyc = 0;
   logic [31:0]             d;
   logic [1:0]              r;
   localparam logic [17:0]  CTRL = sbhm_pkg::SBHM_ADDR_STANDBY_CONTROL;
   // mode, hold, source (0 nmi, 1 first pin, 2 second pin, 3 internal), released, clocks, pins
   sbhm_row_t rows [14] = '{
      '{2'h0, 1'b0, 2'h3, 1'b1, 6'h3E, 4'h0}, '{2'h0, 1'b0, 2'h1, 1'b1, 6'h3E, 4'h0},
      '{2'h0, 1'b0, 2'h2, 1'b1, 6'h3E, 4'h0}, '{2'h0, 1'b0, 2'h0, 1'b1, 6'h3E, 4'h0},
      '{2'h3, 1'b0, 2'h3, 1'b1, 6'h26, 4'h0}, '{2'h3, 1'b0, 2'h1, 1'b0, 6'h26, 4'h0},
      '{2'h3, 1'b0, 2'h2, 1'b0, 6'h26, 4'h0}, '{2'h3, 1'b0, 2'h0, 1'b1, 6'h26, 4'h0},
      '{2'h2, 1'b0, 2'h3, 1'b0, 6'h31, 4'h0}, '{2'h2, 1'b0, 2'h1, 1'b0, 6'h31, 4'h0},
      '{2'h2, 1'b0, 2'h0, 1'b1, 6'h31, 4'h0}, '{2'h1, 1'b0, 2'h3, 1'b0, 6'h00, 4'h7},
      '{2'h1, 1'b0, 2'h2, 1'b0, 6'h00, 4'h7}, '{2'h1, 1'b1, 2'h3, 1'b0, 6'h01, 4'h9}};
   always #12.5 aclk = ~aclk;
   // ----------------------------------------
   // parts
   // ----------------------------------------
   sbhm_partner peer (.aclk(aclk), .halted(halted), .go(go), .fire(fire), .rst_req(rst_req),
      .aresetn(aresetn), .nmi_n(nmi_n), .first_external_irq(first_external_irq),
      .second_external_irq(second_external_irq));
   sbhm_ctrl DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .halt_exec(halt_exec),
      .exx_exec(exx_exec), .nmi_n(nmi_n), .first_external_irq(first_external_irq),
      .second_external_irq(second_external_irq), .int_irq(int_irq), .halted(halted),
      .halt_release(halt_release), .clk_ctl(clk_ctl), .pin_ctl(pin_ctl));
   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic conclude();
      $display("checks %0d, mismatches %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // address and data go out together; each is released once taken
   task automatic axw(input logic [17:0] a, input logic [31:0] v, output logic [1:0] resp);
      logic aw_ok, w_ok;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      awaddr <= a; wdata <= v; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
      while (!(aw_ok && w_ok))
      begin
         @(posedge aclk);
         if (awvalid && awready) begin aw_ok = 1'b1; awvalid <= 1'b0; end
         if (wvalid && wready) begin w_ok = 1'b1; wvalid <= 1'b0; end
      end
      do @(posedge aclk); while (bvalid !== 1'b1);
      resp = bresp;
      bready <= 1'b0;
   endtask
   task automatic axr(input logic [17:0] a, output logic [31:0] v, output logic [1:0] resp);
      araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
      do @(posedge aclk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge aclk); while (rvalid !== 1'b1);
      v = rdata;
      resp = rresp;
      rready <= 1'b0;
   endtask
   always @(posedge aclk)
   begin
      cyc++;
      if (cyc == 20000) begin errors++; conclude(); end
   end
   // ----------------------------------------
   // sequence
   // ----------------------------------------
   initial
   begin
      int n;
      do @(posedge aclk); while (aresetn !== 1'b1);
      chk(32'(halted), 32'h0);
      chk(32'(clk_ctl), 32'h3E);
      axr(CTRL, d, r);
      chk(d, 32'h0);
      chk(32'(r), 32'(sbhm_pkg::SBHM_RESP_OKAY));
      for (int i = 0; i < 14; i++)
      begin
         axw(CTRL, {28'h0, rows[i].mode, 1'b0, rows[i].hold}, r);
         @(posedge aclk) halt_exec <= 1'b1;
         @(posedge aclk) halt_exec <= 1'b0;
         @(posedge aclk);
         chk(32'(halted), 32'h1);
         chk(32'(clk_ctl), 32'(rows[i].clk));
         chk(32'(pin_ctl), 32'(rows[i].pin));
         if (rows[i].src == 2'h3)
            int_irq <= 6'(6'h20 >> (i % 6));
         else
         begin
            go <= 1'b1;
            fire <= rows[i].src;
         end
         @(posedge aclk) go <= 1'b0;
         n = 0;
         while (halted === 1'b1 && n < 16) begin @(posedge aclk); n++; end
         chk(32'(!halted), 32'(rows[i].rel));
         if (rows[i].rel)
         begin
            @(posedge aclk);
            chk(32'(halt_release), 32'h1);
            chk(32'(clk_ctl), 32'h3E);
         end
         else
         begin
            // a refused wake leaves the halt standing; only reset clears it
            rst_req <= 1'b1;
            @(posedge aclk) rst_req <= 1'b0;
            do @(posedge aclk); while (aresetn !== 1'b1);
            @(posedge aclk);
            chk(32'(halted), 32'h0);
            chk(32'(pin_ctl), 32'h0);
         end
         int_irq <= '0;
         repeat (6) @(posedge aclk);
      end
      axr(18'h00000, d, r);
      chk(32'(r), 32'(sbhm_pkg::SBHM_RESP_SLVERR));
      chk(d, 32'h0);
      axw(18'h00004, 32'hFF, r);
      chk(32'(r), 32'(sbhm_pkg::SBHM_RESP_SLVERR));
      axw(CTRL, 32'h0F, r);
      chk(32'(r), 32'(sbhm_pkg::SBHM_RESP_OKAY));
      axr(CTRL, d, r);
      chk(d, 32'h0D);
      @(posedge aclk) exx_exec <= 1'b1;
      @(posedge aclk) exx_exec <= 1'b0;
      axr(CTRL, d, r);
      chk(d, 32'h0F);
      // the last halt ended by reset, so the latched mode reads back as run
      axr(sbhm_pkg::SBHM_ADDR_STATUS, d, r);
      chk(d, 32'h18);
      conclude();
   end
endmodule
